// [core/hlpd_pkg.sv]
// constants, mode enumeration and pin carrier for the line powerdown host
// assumes a single 50 MHz clock and no software-visible registers
`default_nettype none
package hlpd_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned NUM_DRV = 3;
  localparam logic [2:0] USED_DRV_MASK = 3'h7;
  // driver resume time after leaving powerdown, microseconds
  localparam int unsigned WAKE_US = 100;
  localparam int unsigned WAKE_CYC = (WAKE_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
    WAKE_US * (CLK_HZ / 1_000_000);
  // force-active pulse on shutdown release, nanoseconds
  localparam int unsigned FPULSE_NS = 1000;
  localparam int unsigned FPULSE_CYC = (FPULSE_NS / (1_000_000_000 / CLK_HZ) < 1) ? 1 :
    FPULSE_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned TMR_W = 16;
  localparam logic [TMR_W-1:0] FPULSE_LOAD = TMR_W'(FPULSE_CYC);

  typedef enum logic [2:0] {
    HLPD_ALWAYS,
    HLPD_AUTO,
    HLPD_SOFT,
    HLPD_TIED,
    HLPD_VALID
  } hlpd_mode_t;

  typedef struct packed {
    logic shutdown_ctl_n;
    logic force_active;
  } hlpd_ctl_t;

  localparam hlpd_ctl_t CTL_RESET = '{shutdown_ctl_n: 1'b0, force_active: 1'b0};
endpackage
`default_nettype wire

// [core/hlpd_timer.sv]
// one-shot down counter with busy level and done pulse
// assumes start is a single-cycle pulse; a new start reloads
`default_nettype none
module hlpd_timer #(
  parameter int unsigned W = 16
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [W-1:0] load_in,
  output logic busy_out,
  output logic done_out
);
  logic [W-1:0] count_reg;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= '0;
    end else if (start_in) begin
      count_reg <= load_in;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - W'(1);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= start_in || (count_reg > W'(1));
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= !start_in && (count_reg == W'(1));
    end
  end
endmodule
`default_nettype wire

// [core/hlpd_host.sv]
// host power manager driving the transceiver's two control pins and driver inputs
// assumes all inputs synchronous to mclk_in; transceiver pins are plain logic levels
`default_nettype none
module hlpd_host
  import hlpd_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire hlpd_mode_t mode_in,
  input wire logic master_on_in,
  input wire logic line_valid_in,
  input wire logic [NUM_DRV-1:0] tx_data_in,
  output logic shutdown_ctl_n_out,
  output logic force_active_out,
  output logic [NUM_DRV-1:0] drv_data_out,
  output logic drv_ready_out
);
  hlpd_mode_t mode_reg;
  hlpd_ctl_t ctl_reg;
  hlpd_ctl_t ctl_next;
  logic master_q_reg;
  logic master_rise;
  logic pulse_busy;
  logic wake_start;
  logic wake_done;
  logic ready_reg;
  logic [NUM_DRV-1:0] drv_reg;

  localparam logic [TMR_W-1:0] WAKE_LOAD = TMR_W'(WAKE_CYCLES);

  assign master_rise = master_on_in && !master_q_reg;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg <= HLPD_ALWAYS;
      master_q_reg <= 1'b0;
    end else begin
      mode_reg <= mode_in;
      master_q_reg <= master_on_in;
    end
  end

  // force-active pulse on master release in auto mode
  hlpd_timer #(.W(TMR_W)) u_pulse (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .start_in(master_rise && (mode_reg == HLPD_AUTO)),
    .load_in(FPULSE_LOAD),
    .busy_out(pulse_busy),
    .done_out()
  );

  // control pin selection per mode
  always_comb begin
    ctl_next = CTL_RESET;
    case (mode_reg)
      HLPD_ALWAYS: begin
        ctl_next = '{shutdown_ctl_n: 1'b1, force_active: 1'b1};
      end
      HLPD_AUTO: begin
        ctl_next = '{shutdown_ctl_n: master_on_in, force_active: pulse_busy};
      end
      HLPD_SOFT: begin
        ctl_next = '{shutdown_ctl_n: master_on_in, force_active: 1'b1};
      end
      HLPD_TIED: begin
        ctl_next = '{shutdown_ctl_n: master_on_in, force_active: master_on_in};
      end
      HLPD_VALID: begin
        ctl_next = '{shutdown_ctl_n: line_valid_in, force_active: line_valid_in};
      end
      default: begin
        ctl_next = CTL_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_reg <= CTL_RESET;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // wait for driver resume after shutdown release
  assign wake_start = ctl_next.shutdown_ctl_n && !ctl_reg.shutdown_ctl_n;

  hlpd_timer #(.W(TMR_W)) u_wake (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .start_in(wake_start),
    .load_in(WAKE_LOAD),
    .busy_out(),
    .done_out(wake_done)
  );

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ready_reg <= 1'b0;
    end else if (!ctl_next.shutdown_ctl_n || wake_start) begin
      ready_reg <= 1'b0;
    end else if (wake_done) begin
      ready_reg <= 1'b1;
    end
  end

  // driver inputs, unused ones grounded
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drv_reg <= '0;
    end else begin
      drv_reg <= tx_data_in & USED_DRV_MASK;
    end
  end

  assign shutdown_ctl_n_out = ctl_reg.shutdown_ctl_n;
  assign force_active_out = ctl_reg.force_active;
  assign drv_data_out = drv_reg;
  assign drv_ready_out = ready_reg;

  property p_tied_pins;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (mode_reg == HLPD_TIED) |=> (ctl_reg.shutdown_ctl_n == ctl_reg.force_active);
  endproperty
  a_tied_pins: assert property (p_tied_pins) else $error("tied pins differ");

  property p_soft_force;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (mode_reg == HLPD_SOFT) |=> ctl_reg.force_active
        && (ctl_reg.shutdown_ctl_n == $past(master_on_in));
  endproperty
  a_soft_force: assert property (p_soft_force) else $error("soft mode pins wrong");

  property p_valid_follow;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (mode_reg == HLPD_VALID) |=> (ctl_reg.shutdown_ctl_n == $past(line_valid_in))
        && (ctl_reg.force_active == $past(line_valid_in));
  endproperty
  a_valid_follow: assert property (p_valid_follow)
    else $error("pins not following validity");

  property p_release_pulse;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (mode_reg == HLPD_AUTO && master_rise) ##1 (mode_reg == HLPD_AUTO)
        |=> ctl_reg.force_active;
  endproperty
  a_release_pulse: assert property (p_release_pulse) else $error("no force pulse");

  property p_pulse_ends;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (mode_reg == HLPD_AUTO && $fell(pulse_busy)) |=> !ctl_reg.force_active;
  endproperty
  a_pulse_ends: assert property (p_pulse_ends) else $error("force pulse stuck high");

  property p_unused_low;
    @(posedge mclk_in) disable iff (!rst_n_in)
      drv_data_out == ($past(tx_data_in) & USED_DRV_MASK);
  endproperty
  a_unused_low: assert property (p_unused_low)
    else $error("driver input not masked copy");

  property p_ready_drop;
    @(posedge mclk_in) disable iff (!rst_n_in)
      !ctl_reg.shutdown_ctl_n |-> !drv_ready_out;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready during shutdown");

  property p_always_pins;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (mode_reg == HLPD_ALWAYS) |=> ctl_reg.shutdown_ctl_n && ctl_reg.force_active;
  endproperty
  a_always_pins: assert property (p_always_pins) else $error("always mode pins low");

  property p_auto_master;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (mode_reg == HLPD_AUTO) |=> (ctl_reg.shutdown_ctl_n == $past(master_on_in));
  endproperty
  a_auto_master: assert property (p_auto_master) else $error("auto pin wrong");

  property p_ready_wait;
    @(posedge mclk_in) disable iff (!rst_n_in)
      $rose(ctl_reg.shutdown_ctl_n) |-> !drv_ready_out ##1 !drv_ready_out;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready too early");

  property p_ready_rise;
    @(posedge mclk_in) disable iff (!rst_n_in)
      $rose(drv_ready_out) |-> $past(wake_done) && ctl_reg.shutdown_ctl_n;
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready without wake wait");

  c_auto_pulse: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    mode_reg == HLPD_AUTO && master_rise);
  c_ready: cover property (@(posedge mclk_in) disable iff (!rst_n_in) $rose(drv_ready_out));
  c_valid_off: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    mode_reg == HLPD_VALID && $fell(shutdown_ctl_n_out));
  c_tied_on: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    mode_reg == HLPD_TIED && $rose(shutdown_ctl_n_out));
endmodule
`default_nettype wire

// [bench/hlpd_xcvr_model.sv]
// transceiver model: powerdown logic, inverting paths, validity flag
// assumes timers run on the host clock with shortened counts
`default_nettype none
module hlpd_xcvr_model #(
  parameter int IDLE_CYC = 300,
  parameter int VH_CYC = 50,
  parameter int VL_CYC = 100
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic shutdown_ctl_n_in,
  input wire logic force_active_in,
  input wire logic [2:0] drv_data_in,
  input wire logic [2:0] rx_line_in,
  input wire logic rx_level_ok_in,
  output logic [2:0] tx_line_out,
  output logic [2:0] rx_data_out,
  output logic line_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] drv_reg, drv_d_reg, rx_reg, rx_d_reg;
  logic frc_reg;
  int idle_reg, vcnt_reg;
  logic active;
  // input synchroniser and edge history
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {drv_reg, drv_d_reg, rx_reg, rx_d_reg, frc_reg} <= '0;
    end else begin
      {drv_reg, rx_reg, frc_reg} <= {drv_data_in, rx_line_in, force_active_in};
      {drv_d_reg, rx_d_reg} <= {drv_reg, rx_reg};
    end
  end
  // inactivity timer, stays expired until an edge or force high
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) idle_reg <= IDLE_CYC;
    else if (!shutdown_ctl_n_in) idle_reg <= IDLE_CYC;
    else if (drv_reg != drv_d_reg || rx_reg != rx_d_reg || frc_reg) idle_reg <= 0;
    else if (idle_reg < IDLE_CYC) idle_reg <= idle_reg + 1;
  end
  assign active = shutdown_ctl_n_in &&
    (force_active_in || idle_reg < IDLE_CYC);
  assign tx_line_out = active ? ~drv_reg : 3'bzzz;
  assign rx_data_out = ~rx_reg;
  // validity flag with rise and fall delays
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vcnt_reg <= 0;
      line_valid_out <= 1'b0;
    end else if (rx_level_ok_in == line_valid_out) vcnt_reg <= 0;
    else if (vcnt_reg == (line_valid_out ? VL_CYC : VH_CYC) - 1) begin
      vcnt_reg <= 0;
      line_valid_out <= !line_valid_out;
    end else vcnt_reg <= vcnt_reg + 1;
  end
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the line powerdown host
// assumes the transceiver model in hlpd_xcvr_model.sv
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module testbench
  import hlpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in, rst_n_in, master_on_in, line_valid, sd, fa, rdy, rx_ok;
  hlpd_mode_t mode_in;
  logic [2:0] tx_data_in, drv, tx_line, rx_line;
  int num_errors = 0, checks_done = 0;
  hlpd_host #(.WAKE_CYCLES(20)) hlpd_host_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .mode_in(mode_in), .master_on_in(master_on_in), .line_valid_in(line_valid),
    .tx_data_in(tx_data_in), .shutdown_ctl_n_out(sd), .force_active_out(fa),
    .drv_data_out(drv), .drv_ready_out(rdy));
  hlpd_xcvr_model hlpd_xcvr_model_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .shutdown_ctl_n_in(sd), .force_active_in(fa), .drv_data_in(drv), .rx_line_in(rx_line),
    .rx_level_ok_in(rx_ok), .tx_line_out(tx_line), .rx_data_out(), .line_valid_out(line_valid));
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  task automatic tick(int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic drive(hlpd_mode_t m, logic mo);
    @(posedge mclk_in);
    mode_in <= m;
    master_on_in <= mo;
    tick(3);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic test_modes;
    drive(HLPD_TIED, 1'b0); `CHK({sd, fa}, 2'b00)
    drive(HLPD_TIED, 1'b1); `CHK({sd, fa}, 2'b11)
    drive(HLPD_SOFT, 1'b0); `CHK({sd, fa}, 2'b01)
    drive(HLPD_SOFT, 1'b1); `CHK({sd, fa}, 2'b11)
    drive(HLPD_ALWAYS, 1'b0); `CHK({sd, fa}, 2'b11)
    $display("test modes done");
  endtask
  task automatic test_auto;
    int n;
    drive(HLPD_AUTO, 1'b0); `CHK({sd, rdy}, 2'b00)
    @(posedge mclk_in);
    master_on_in <= 1'b1;
    tick(3); `CHK({sd, fa, rdy}, 3'b110)
    n = 0;
    while (fa === 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    `CHK(n, FPULSE_CYC - 1)
    `CHK({sd, fa, rdy}, 3'b101)
    @(posedge mclk_in);
    master_on_in <= 1'b0;
    tick(2); `CHK({sd, rdy}, 2'b00)
    $display("test auto done");
  endtask
  task automatic test_data;
    drive(HLPD_TIED, 1'b1);
    tick(25); `CHK(rdy, 1'b1)
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk_in);
      tx_data_in <= 3'(i);
      tick(2); `CHK(drv, 3'(i))
      `CHK(tx_line, ~3'(i))
    end
    $display("test data done");
  endtask
  task automatic test_valid;
    drive(HLPD_VALID, 1'b1); `CHK({sd, fa}, 2'b00)
    @(posedge mclk_in);
    rx_ok <= 1'b1;
    tick(55); `CHK({sd, fa}, 2'b11)
    @(posedge mclk_in);
    rx_ok <= 1'b0;
    tick(105); `CHK({sd, fa, rdy}, 3'b000)
    $display("test valid done");
  endtask
  initial begin
    tick(5000);
    num_errors++;
    stop_test();
  end
  initial begin
    {rst_n_in, master_on_in, rx_ok} = '0;
    mode_in = HLPD_AUTO;
    tx_data_in = 3'h0;
    rx_line = 3'h0;
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    test_modes();
    test_auto();
    test_data();
    test_valid();
    stop_test();
  end
endmodule
`default_nettype wire
